/* rtl/link_cmd_pkg.sv */
// constants shared by both ends of the link command exchange
// assumes one 100 MHz clock, asynchronous active-high reset
package link_cmd_pkg;
  localparam logic [7:0] OP_SET_LINK = 8'h09;
  localparam logic [7:0] OP_SET_LINK_RSP = 8'h89;
  localparam logic [7:0] OP_GET_STATUS = 8'h0a;
  localparam logic [7:0] OP_GET_STATUS_RSP = 8'h8a;
  localparam int BIT_AUTONEG = 0;
  localparam int BIT_HALF = 8;
  localparam int BIT_FULL = 9;
  localparam int BIT_PAUSE_OFF = 10;
  localparam int BIT_ASYM = 11;
  localparam int BIT_VENDOR_OK = 12;
  localparam int BIT_SPD_1G = 3;
  localparam logic [31:0] SPEED_MASK = 32'h0001_e0fe;
  localparam logic [31:0] USED_MASK = 32'h0001_ffff;
  localparam logic [15:0] RSP_OK = 16'h0000;
  localparam logic [15:0] RSP_FAILED = 16'h0001;
  localparam logic [15:0] RSN_NONE = 16'h0000;
  localparam logic [15:0] RSN_PARAM_INVALID = 16'h0002;
  localparam logic [15:0] RSN_DRIVER_CONFLICT = 16'h0901;
  localparam logic [15:0] RSN_MEDIA_CONFLICT = 16'h0902;
  localparam logic [15:0] RSN_PARAM_CONFLICT = 16'h0903;
  localparam logic [15:0] RSN_POWER_CONFLICT = 16'h0904;
  localparam logic [15:0] RSN_SPEED_CONFLICT = 16'h0905;
  localparam logic [15:0] RSN_PHY_ERROR = 16'h0906;
  localparam logic [31:0] LINK_CFG_RST = 32'h0000_0001;
  localparam int PHY_WAIT_MAX = 8;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_SETTINGS = 8'h04;
  localparam logic [7:0] APB_VENDOR = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam logic [7:0] APB_RSP = 8'h10;
  localparam logic [7:0] APB_LINK_STAT = 8'h14;
  localparam logic [7:0] APB_OTHER = 8'h18;
  localparam logic [7:0] APB_VENDOR_STAT = 8'h1c;
endpackage : link_cmd_pkg

/* rtl/link_cmd_if.sv */
// command/response carrier between management controller and channel
// assumes both ends share clk_i
`timescale 1ns/1ps
interface link_cmd_if;
  logic cmd_valid;
  logic [7:0] cmd_opcode;
  logic [31:0] cmd_settings;
  logic [31:0] cmd_vendor;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_opcode;
  logic [15:0] rsp_code;
  logic [15:0] rsp_reason;
  logic [31:0] rsp_link_status;
  logic [31:0] rsp_other;
  logic [31:0] rsp_vendor_status;
  modport ctrl (output cmd_valid, cmd_opcode, cmd_settings, cmd_vendor,
    input cmd_ready, rsp_valid, rsp_opcode, rsp_code, rsp_reason, rsp_link_status, rsp_other, rsp_vendor_status);
  modport dev (input cmd_valid, cmd_opcode, cmd_settings, cmd_vendor,
    output cmd_ready, rsp_valid, rsp_opcode, rsp_code, rsp_reason, rsp_link_status, rsp_other, rsp_vendor_status);
endinterface : link_cmd_if

/* rtl/one_hot_check.sv */
// flags when more than one bit of a vector is set
// assumes a purely combinational use
`timescale 1ns/1ps
module one_hot_check
  import link_cmd_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic [W-1:0] vec_i,
  output logic multi_o
);
  always_comb begin
    multi_o = (vec_i & (vec_i - W'(1))) != '0;
  end
endmodule : one_hot_check

/* rtl/link_cmd_device.sv */
// channel end: decodes set link and get link status, answers each command
// assumes the controller holds cmd_valid until cmd_ready; phy result arrives with phy_done_i
`timescale 1ns/1ps
module link_cmd_device
  import link_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  link_cmd_if.dev lnk,
  input wire logic [31:0] supported_i,
  input wire logic [31:0] media_ok_i,
  input wire logic [31:0] power_ok_i,
  input wire logic driver_active_i,
  input wire logic link_up_i,
  input wire logic [31:0] other_ind_i,
  input wire logic [31:0] vendor_stat_i,
  input wire logic phy_done_i,
  input wire logic phy_err_i,
  output logic phy_req_o,
  output logic phy_wr_o,
  output logic [31:0] link_cfg_o,
  output logic [31:0] vendor_cfg_o
);
  typedef enum logic [1:0] {IDLE, PHY, RESP} dev_state_e;
  typedef struct packed {
    dev_state_e st;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_opcode;
    logic [15:0] rsp_code;
    logic [15:0] rsp_reason;
    logic [31:0] rsp_link_status;
    logic [31:0] rsp_other;
    logic [31:0] rsp_vendor_status;
    logic phy_req;
    logic phy_wr;
    logic [31:0] pend_cfg;
    logic [31:0] pend_vendor;
    logic [31:0] link_cfg;
    logic [31:0] vendor_cfg;
    logic [3:0] phy_wait;
  } dev_s;
  dev_s s_r;
  dev_s s_nxt;
  logic [31:0] req;
  logic [31:0] spd;
  logic [31:0] dup;
  logic multi_speed;
  logic multi_dup;
  logic forced;
  logic spd_unsup;
  logic dup_unsup;
  logic no_choice;
  logic media_clash;
  logic half_gig;
  logic power_short;
  logic [15:0] set_reason;
  logic [31:0] an_cfg;
  assign req = lnk.cmd_settings & USED_MASK;
  assign spd = req & SPEED_MASK;
  assign dup = req & ((32'h1 << BIT_HALF) | (32'h1 << BIT_FULL));
  assign forced = !req[BIT_AUTONEG];
  assign spd_unsup = (spd & ~supported_i) != '0;
  assign dup_unsup = (dup & ~supported_i) != '0;
  // a forced link needs exactly one speed and one duplex setting
  assign no_choice = (spd == '0) || (dup == '0);
  assign media_clash = (req & ~media_ok_i & (SPEED_MASK | dup)) != '0;
  // half duplex at 1 Gbps contradicts itself whatever the support mask says
  assign half_gig = req[BIT_HALF] && req[BIT_SPD_1G];
  // a power clash only when no requested speed is both supported and allowed now
  assign power_short = ((spd & ~power_ok_i) != '0) && ((spd & supported_i & power_ok_i) == '0);
  // autoneg drops unsupported speed and duplex bits instead of failing
  assign an_cfg = req & (supported_i | ~(SPEED_MASK | dup));
  one_hot_check #(.W(32)) u_spd (.vec_i(spd), .multi_o(multi_speed));
  one_hot_check #(.W(32)) u_dup (.vec_i(dup), .multi_o(multi_dup));
  // failure reasons in priority order; RSN_NONE lets the command reach the phy
  always_comb begin
    set_reason = RSN_NONE;
    if (driver_active_i) begin
      set_reason = RSN_DRIVER_CONFLICT;
    end else if (forced && multi_speed) begin
      set_reason = RSN_SPEED_CONFLICT;
    end else if (forced && (multi_dup || spd_unsup || dup_unsup || no_choice)) begin
      set_reason = RSN_PARAM_INVALID;
    end else if (forced && media_clash) begin
      set_reason = RSN_MEDIA_CONFLICT;
    end else if (forced && half_gig) begin
      set_reason = RSN_PARAM_CONFLICT;
    end else if (power_short) begin
      set_reason = RSN_POWER_CONFLICT;
    end
  end
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd_ready = 1'b0;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.phy_req = 1'b0;
    unique case (s_r.st)
      IDLE: begin
        if (lnk.cmd_valid && !s_r.cmd_ready) begin
          s_nxt.cmd_ready = 1'b1;
          s_nxt.rsp_code = RSP_OK;
          s_nxt.rsp_reason = RSN_NONE;
          s_nxt.rsp_link_status = '0;
          s_nxt.rsp_other = '0;
          s_nxt.rsp_vendor_status = '0;
          s_nxt.st = RESP;
          s_nxt.phy_wait = '0;
          if (lnk.cmd_opcode == OP_SET_LINK) begin
            s_nxt.rsp_opcode = OP_SET_LINK_RSP;
            s_nxt.rsp_code = RSP_FAILED;
            s_nxt.rsp_reason = set_reason;
            if (set_reason == RSN_NONE) begin
              s_nxt.rsp_code = RSP_OK;
              s_nxt.pend_cfg = forced ? req : an_cfg;
              // a clear valid bit keeps the vendor word already applied
              s_nxt.pend_vendor = req[BIT_VENDOR_OK] ? lnk.cmd_vendor : s_r.vendor_cfg;
              s_nxt.phy_req = 1'b1;
              s_nxt.phy_wr = 1'b1;
              s_nxt.st = PHY;
            end
          end else if (lnk.cmd_opcode == OP_GET_STATUS) begin
            s_nxt.rsp_opcode = OP_GET_STATUS_RSP;
            s_nxt.phy_req = 1'b1;
            s_nxt.phy_wr = 1'b0;
            s_nxt.st = PHY;
          end else begin
            s_nxt.rsp_opcode = lnk.cmd_opcode | 8'h80;
            s_nxt.rsp_code = RSP_FAILED;
            s_nxt.rsp_reason = RSN_PARAM_INVALID;
          end
        end
      end
      PHY: begin
        s_nxt.phy_wait = s_r.phy_wait + 4'h1;
        if (phy_done_i) begin
          s_nxt.st = RESP;
          if (phy_err_i) begin
            s_nxt.rsp_code = RSP_FAILED;
            s_nxt.rsp_reason = RSN_PHY_ERROR;
          end else if (s_r.phy_wr) begin
            s_nxt.link_cfg = s_r.pend_cfg;
            s_nxt.vendor_cfg = s_r.pend_vendor;
          end else begin
            // low-power idle keeps link_up_i high, so it never reads as down
            s_nxt.rsp_link_status = {31'h0, link_up_i};
            s_nxt.rsp_other = other_ind_i;
            s_nxt.rsp_vendor_status = vendor_stat_i;
          end
        end else if (s_r.phy_wait == 4'(PHY_WAIT_MAX - 1)) begin
          // a phy that never answers must not hang the command
          s_nxt.st = RESP;
          s_nxt.rsp_code = RSP_FAILED;
          s_nxt.rsp_reason = RSN_PHY_ERROR;
        end
      end
      RESP: begin
        s_nxt.rsp_valid = 1'b1;
        s_nxt.st = IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '{st: IDLE, link_cfg: LINK_CFG_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign lnk.cmd_ready = s_r.cmd_ready;
  assign lnk.rsp_valid = s_r.rsp_valid;
  assign lnk.rsp_opcode = s_r.rsp_opcode;
  assign lnk.rsp_code = s_r.rsp_code;
  assign lnk.rsp_reason = s_r.rsp_reason;
  assign lnk.rsp_link_status = s_r.rsp_link_status;
  assign lnk.rsp_other = s_r.rsp_other;
  assign lnk.rsp_vendor_status = s_r.rsp_vendor_status;
  assign phy_req_o = s_r.phy_req;
  assign phy_wr_o = s_r.phy_wr;
  assign link_cfg_o = s_r.link_cfg;
  assign vendor_cfg_o = s_r.vendor_cfg;
endmodule : link_cmd_device

/* rtl/link_cmd_ctrl.sv */
// management controller end: apb slave registers issue commands and hold answers
// assumes an apb master on the software side
`timescale 1ns/1ps
module link_cmd_ctrl
  import link_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  link_cmd_if.ctrl lnk
);
  typedef struct packed {
    logic busy;
    logic done;
    logic cmd_valid;
    logic [7:0] opcode;
    logic [31:0] settings;
    logic [31:0] vendor;
    logic [31:0] rsp;
    logic [31:0] link_stat;
    logic [31:0] other;
    logic [31:0] vendor_stat;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctrl_s;
  ctrl_s s_r;
  ctrl_s s_nxt;
  logic acc;
  assign acc = psel_i && penable_i && !s_r.pready;
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (lnk.cmd_valid && lnk.cmd_ready) begin
      s_nxt.cmd_valid = 1'b0;
    end
    if (lnk.rsp_valid) begin
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.rsp = {lnk.rsp_code, lnk.rsp_reason};
      s_nxt.link_stat = lnk.rsp_link_status;
      s_nxt.other = lnk.rsp_other;
      s_nxt.vendor_stat = lnk.rsp_vendor_status;
    end
    if (acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = '0;
      if (pwrite_i) begin
        unique case (paddr_i)
          APB_CMD: begin
            // a command while one is in flight is refused with pslverr
            if (s_r.busy) begin
              s_nxt.pslverr = 1'b1;
            end else begin
              s_nxt.opcode = pwdata_i[7:0];
              s_nxt.cmd_valid = 1'b1;
              s_nxt.busy = 1'b1;
              s_nxt.done = 1'b0;
            end
          end
          APB_SETTINGS: s_nxt.settings = pwdata_i & USED_MASK;
          APB_VENDOR: s_nxt.vendor = pwdata_i;
          default: s_nxt.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr_i)
          APB_CMD: s_nxt.prdata = {24'h0, s_r.opcode};
          APB_SETTINGS: s_nxt.prdata = s_r.settings;
          APB_VENDOR: s_nxt.prdata = s_r.vendor;
          APB_STATUS: s_nxt.prdata = {30'h0, s_r.done, s_r.busy};
          APB_RSP: s_nxt.prdata = s_r.rsp;
          APB_LINK_STAT: s_nxt.prdata = s_r.link_stat;
          APB_OTHER: s_nxt.prdata = s_r.other;
          APB_VENDOR_STAT: s_nxt.prdata = s_r.vendor_stat;
          default: s_nxt.pslverr = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign lnk.cmd_valid = s_r.cmd_valid;
  assign lnk.cmd_opcode = s_r.opcode;
  assign lnk.cmd_settings = s_r.settings;
  assign lnk.cmd_vendor = s_r.vendor;
endmodule : link_cmd_ctrl

/* verif/link_cmd_checker.sv */
// assertions on the command/response carrier between the two ends
// assumes plain copies of the interface signals, one clock domain
`timescale 1ns/1ps
module link_cmd_checker
  import link_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [31:0] cmd_settings,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_opcode,
  input wire logic [15:0] rsp_code,
  input wire logic [15:0] rsp_reason
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // opcode of the accepted command, needed to judge the answer that follows
  logic [7:0] op_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) op_r <= 8'h00;
    else if (cmd_ready) op_r <= cmd_opcode;
  end
  chk_ready_next: assert property ($rose(cmd_valid) |=> cmd_ready)
    else $error("command not taken on time");
  chk_cmd_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_opcode))
    else $error("command dropped before accept");
  chk_rsv_zero: assert property (cmd_valid |-> cmd_settings[31:17] == 15'h0000)
    else $error("reserved settings bits sent");
  chk_rsp_bound: assert property (cmd_ready |-> ##[1:20] rsp_valid)
    else $error("no answer to command");
  chk_rsp_opcode: assert property (rsp_valid |-> rsp_opcode == (op_r | 8'h80))
    else $error("answer opcode wrong");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  chk_ok_reason: assert property (rsp_valid && rsp_code == RSP_OK |-> rsp_reason == RSN_NONE)
    else $error("success with reason");
  chk_fail_code: assert property (rsp_valid && rsp_reason != RSN_NONE |-> rsp_code == RSP_FAILED)
    else $error("reason without failure");
  chk_status_ok: assert property (rsp_valid && rsp_opcode == OP_GET_STATUS_RSP
    |-> rsp_reason == RSN_NONE || rsp_reason == RSN_PHY_ERROR)
    else $error("status query refused");
endmodule : link_cmd_checker

/* verif/tb.sv */
// self-checking bench: apb master on the controller end, phy and link inputs on the device end
// assumes both design ends joined by link_cmd_if and a phy that finishes one cycle after a request, or never when muted
`timescale 1ns/1ps
module tb
  import link_cmd_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, supported_i, media_ok_i, power_ok_i, other_ind_i, vendor_stat_i;
  logic driver_active_i, link_up_i, phy_done_i, phy_err_i, phy_req_o, phy_wr_o, phy_mute;
  logic [31:0] link_cfg_o, vendor_cfg_o, d;
  logic [31:0] lfsr = 32'h74aff722;
  logic [31:0] tbl[9] = '{32'h208, 32'h108, 32'h20c, 32'h308, 32'h280, 32'h200, 32'he04, 32'h8381, 32'h1301};
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  link_cmd_if lnk();
  link_cmd_ctrl link_cmd_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .lnk(lnk));
  link_cmd_device link_cmd_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk), .supported_i(supported_i),
    .media_ok_i(media_ok_i), .power_ok_i(power_ok_i), .driver_active_i(driver_active_i), .link_up_i(link_up_i),
    .other_ind_i(other_ind_i), .vendor_stat_i(vendor_stat_i), .phy_done_i(phy_done_i), .phy_err_i(phy_err_i),
    .phy_req_o(phy_req_o), .phy_wr_o(phy_wr_o), .link_cfg_o(link_cfg_o), .vendor_cfg_o(vendor_cfg_o));
  link_cmd_checker link_cmd_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid(lnk.cmd_valid),
    .cmd_opcode(lnk.cmd_opcode), .cmd_settings(lnk.cmd_settings), .cmd_ready(lnk.cmd_ready),
    .rsp_valid(lnk.rsp_valid), .rsp_opcode(lnk.rsp_opcode), .rsp_code(lnk.rsp_code), .rsp_reason(lnk.rsp_reason));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) phy_done_i <= phy_req_o && !phy_mute;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic results;
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; a clock edge with psel low always follows, so calls may be chained
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic err);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    d = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  function automatic logic [15:0] exp_rsn(input logic [31:0] s);
    logic [31:0] sp;
    sp = s & SPEED_MASK;
    if (driver_active_i) return RSN_DRIVER_CONFLICT;
    if (!s[0]) begin
      if ($countones(sp) > 1) return RSN_SPEED_CONFLICT;
      if ($countones(s[9:8]) != 1 || sp == 0 || (s & ~supported_i & (SPEED_MASK | 32'h300)) != 0)
        return RSN_PARAM_INVALID;
      if ((s & ~media_ok_i & (SPEED_MASK | 32'h300)) != 0) return RSN_MEDIA_CONFLICT;
      if (s[3] && s[8]) return RSN_PARAM_CONFLICT;
    end
    if ((sp & ~power_ok_i) != 0 && (sp & supported_i & power_ok_i) == 0) return RSN_POWER_CONFLICT;
    return RSN_NONE;
  endfunction : exp_rsn
  // autoneg drops unsupported speed and duplex bits; bits 17 up never reach the device
  function automatic logic [31:0] exp_cfg(input logic [31:0] s);
    return s & 32'h0001_ffff & ~(s[0] ? ~supported_i & (SPEED_MASK | 32'h300) : 32'h0);
  endfunction : exp_cfg
  task automatic run(input logic [7:0] op, input logic [31:0] s, input logic [31:0] v);
    logic e_bus;
    logic [15:0] e;
    logic [31:0] cfg0, ven0;
    cfg0 = link_cfg_o;
    ven0 = vendor_cfg_o;
    xfer(1'b1, APB_SETTINGS, s, e_bus);
    // inputs set just before the call have settled by now
    if (op == OP_SET_LINK) e = exp_rsn(s);
    else if (op == OP_GET_STATUS) e = RSN_NONE;
    else e = RSN_PARAM_INVALID;
    if (e == RSN_NONE && (phy_err_i || phy_mute)) e = RSN_PHY_ERROR;
    xfer(1'b1, APB_VENDOR, v, e_bus);
    xfer(1'b1, APB_CMD, {24'h0, op}, e_bus);
    chk({31'h0, e_bus}, 32'h0, "cmd write error");
    xfer(1'b0, APB_STATUS, 32'h0, e_bus);
    for (int i = 0; i < 50 && d[1:0] !== 2'b10; i++) xfer(1'b0, APB_STATUS, 32'h0, e_bus);
    xfer(1'b0, APB_RSP, 32'h0, e_bus);
    chk(d, {(e == RSN_NONE) ? RSP_OK : RSP_FAILED, e}, "response");
    if (e == RSN_NONE || e == RSN_PHY_ERROR) begin
      chk({31'h0, phy_wr_o}, {31'h0, op == OP_SET_LINK}, "phy direction");
    end
    if (op == OP_SET_LINK) begin
      chk(link_cfg_o, (e == RSN_NONE) ? exp_cfg(s) : cfg0, "link config");
      chk(vendor_cfg_o, (e == RSN_NONE && s[12]) ? v : ven0, "vendor config");
    end else if (op == OP_GET_STATUS) begin
      xfer(1'b0, APB_LINK_STAT, 32'h0, e_bus);
      chk(d, {31'h0, link_up_i && e == RSN_NONE}, "link flag");
      xfer(1'b0, APB_OTHER, 32'h0, e_bus);
      chk(d, (e == RSN_NONE) ? other_ind_i : 32'h0, "other");
      xfer(1'b0, APB_VENDOR_STAT, 32'h0, e_bus);
      chk(d, (e == RSN_NONE) ? vendor_stat_i : 32'h0, "vendor status");
    end
  endtask : run
  initial begin
    logic err;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, phy_err_i, phy_mute} = '0;
    {driver_active_i, link_up_i, other_ind_i, vendor_stat_i} = '0;
    supported_i = 32'h0001_7f7f;
    media_ok_i = 32'hffff_ffff;
    power_ok_i = 32'hffff_ffff;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk(link_cfg_o, LINK_CFG_RST, "reset config");
    xfer(1'b0, 8'h20, 32'h0, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    foreach (tbl[i]) run(OP_SET_LINK, tbl[i], 32'h0000_5a00 + i);
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      run(OP_SET_LINK, lfsr | 32'h3, nxt(lfsr));
    end
    media_ok_i <= ~32'h10;
    run(OP_SET_LINK, 32'h210, 32'h0);
    media_ok_i <= 32'hffff_ffff;
    power_ok_i <= 32'h4;
    run(OP_SET_LINK, 32'h30b, 32'h0);
    power_ok_i <= 32'hffff_ffff;
    driver_active_i <= 1'b1;
    run(OP_SET_LINK, 32'h208, 32'h0);
    driver_active_i <= 1'b0;
    run(8'h0b, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      link_up_i <= lfsr[0];
      other_ind_i <= lfsr;
      vendor_stat_i <= ~lfsr;
      phy_err_i <= (i == 3);
      @(posedge clk_i);
      run(OP_GET_STATUS, 32'h0, 32'h0);
    end
    run(OP_SET_LINK, 32'h204, 32'h0);
    phy_err_i <= 1'b0;
    phy_mute <= 1'b1;
    run(OP_SET_LINK, 32'h1301, 32'h77);
    phy_mute <= 1'b0;
    run(OP_GET_STATUS, 32'h0, 32'h0);
    results();
  end
endmodule : tb
